// File: src/acc_pkg.sv
// Constants, register map and codes for the ARINC 429 channel configuration block
package acc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets (APB, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RX_RATE = 8'h00;
  localparam logic [7:0] ADDR_TX_RATE = 8'h04;
  localparam logic [7:0] ADDR_RX_CTRL = 8'h08;
  localparam logic [7:0] ADDR_TX_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_GLOBAL = 8'h10;
  localparam logic [7:0] ADDR_TIMER_LO = 8'h14;
  localparam logic [7:0] ADDR_TIMER_HI = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // RX_CTRL
  localparam int RXC_PARITY_EN = 0;
  localparam int RXC_LOOPBACK = 1;
  localparam int RXC_QUEUE_EN = 2;
  localparam int RXC_SHARED = 3;
  // TX_CTRL
  localparam int TXC_PARITY_LSB = 0;
  localparam int TXC_QUEUE_EN = 2;
  localparam int TXC_OUTPUT_OFF = 3;
  localparam int TXC_GAP_SHORT = 4;
  localparam int TXC_EDGE_FAST = 5;
  localparam int TXC_SIZE_LSB = 8;
  // GLOBAL
  localparam int GLB_KEY = 0;
  localparam int GLB_STAMP_LSB = 4;
  localparam int GLB_TIMER_CLR = 8;
  // STATUS
  localparam int STS_TX_BUSY = 0;
  localparam int STS_RX_PERR = 1;
  localparam int STS_TX_SLOW = 2;
  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [15:0] RATE_FAST = 16'h0000;
  localparam logic [15:0] RATE_SLOW = 16'h0001;
  localparam logic [1:0] PARITY_ODD_CODE = 2'h0;
  localparam logic [1:0] PARITY_EVEN_CODE = 2'h1;
  localparam logic [1:0] PARITY_OFF_CODE = 2'h2;
  localparam logic LOOPBACK_ON_CODE = 1'b0;
  localparam logic LOOPBACK_OFF_CODE = 1'b1;
  localparam logic [3:0] SIZE_MISSING_CODE = 4'h0;
  localparam logic [3:0] SIZE_EXTRA_CODE = 4'h1;
  localparam logic [3:0] SIZE_NONE_CODE = 4'h8;
  localparam logic KEY_BY_LABEL = 1'b0;
  localparam logic KEY_BY_LABEL_AND_SDI = 1'b1;
  localparam logic [2:0] STAMP_EXTERNAL_TIME = 3'h0;
  localparam logic [2:0] STAMP_INTERNAL_MICRO = 3'h1;
  localparam logic [2:0] STAMP_INTERNAL_TWENTY_MICRO = 3'h3;
  localparam logic [2:0] STAMP_INTERNAL_MILLI = 3'h4;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_RX_CTRL = 32'h0000000E;
  localparam logic [31:0] RST_TX_CTRL = 32'h00000804;
  localparam logic [31:0] RST_GLOBAL = 32'h00000010;
  // ----------------------------------------------------------------
  // Timing: reference 16 MHz, system 250 MHz
  // ----------------------------------------------------------------
  localparam int REF_HZ = 16000000;
  localparam int FAST_BAUD = 100000;
  localparam int SLOW_BAUD = 12500;
  localparam int SLEW_LIMIT_HZ = 15000;
  // Divisor = 16e6 / baud
  localparam logic [16:0] FAST_DIV = 17'(REF_HZ / FAST_BAUD);
  localparam logic [16:0] SLOW_DIV = 17'(REF_HZ / SLOW_BAUD);
  // Setting+2 above this means baud below 15 kHz
  localparam logic [16:0] SLEW_DIV_LIMIT = 17'(REF_HZ / SLEW_LIMIT_HZ);
  localparam int SYS_HZ = 250000000;
  localparam int STAMP_US = 1;
  localparam int SYS_PER_US = SYS_HZ / 1000000 * STAMP_US;
  localparam int REF_PER_US = REF_HZ / 1000000;
  localparam int STD_BITS = 32;
  localparam int STD_GAP = 4;
  localparam int SHORT_GAP = 3;
  localparam int LABEL_W = 8;
  localparam int SDI_W = 2;
  localparam int US_PER_TWENTY = 20;
  localparam int US_PER_MILLI = 1000;
  // ----------------------------------------------------------------
  // Shared decode
  // ----------------------------------------------------------------
  // Cycles of the reference per bit for a rate setting
  function automatic logic [16:0] acc_rate_div(input logic [15:0] setting);
    if (setting == RATE_FAST) begin
      return FAST_DIV;
    end else if (setting == RATE_SLOW) begin
      return SLOW_DIV;
    end
    return {1'b0, setting} + 17'h00002;
  endfunction : acc_rate_div
endpackage : acc_pkg

// File: src/acc_bit_timer.sv
// Reference-clock tick and bit-time tick generator for one channel
`timescale 1ns/1ns
module acc_bit_timer
  import acc_pkg::*;
#(
  parameter int REF_DIV = SYS_HZ / REF_HZ
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_restart,
  input wire logic [15:0] i_rate,
  output logic o_bit_tick
);
  logic [16:0] cnt_reg;
  logic ref_tick;
  logic [16:0] div;

  // ----------------------------------------------------------------
  // 16 MHz reference tick, fractional from 250 MHz (15.625 average)
  // ----------------------------------------------------------------
  // Phase accumulator: tick whenever 16 per 250 is owed
  logic [8:0] ph_reg;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ph_reg <= 9'h000;
    end else if (ph_reg + 9'(REF_HZ / 1000000) >= 9'(SYS_HZ / 1000000)) begin
      ph_reg <= ph_reg + 9'(REF_HZ / 1000000) - 9'(SYS_HZ / 1000000);
    end else begin
      ph_reg <= ph_reg + 9'(REF_HZ / 1000000);
    end
  end
  assign ref_tick = (ph_reg + 9'(REF_HZ / 1000000) >= 9'(SYS_HZ / 1000000));

  // Divide the reference by setting+2, or the standard divisor
  // Two ticks per bit time: one at mid-bit and one at the end
  assign div = acc_rate_div(i_rate);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 17'h00000;
      o_bit_tick <= 1'b0;
    end else if (i_restart) begin
      cnt_reg <= 17'h00000;
      o_bit_tick <= 1'b0;
    end else begin
      o_bit_tick <= 1'b0;
      if (ref_tick) begin
        if (cnt_reg + 17'h00001 >= div) begin
          cnt_reg <= 17'h00000;
          o_bit_tick <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 17'h00001;
          o_bit_tick <= (cnt_reg + 17'h00001 == {1'b0, div[16:1]});
        end
      end
    end
  end
endmodule : acc_bit_timer

// File: src/acc_timestamp.sv
// Internal microsecond timer and time-stamp selection
`timescale 1ns/1ns
module acc_timestamp
  import acc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clear,
  input wire logic [2:0] i_mode,
  input wire logic [63:0] i_ext_time,
  output logic [63:0] o_stamp
);
  logic [7:0] pre_reg;
  logic [63:0] us_reg;
  logic [4:0] tw_pre_reg;
  logic [9:0] ms_pre_reg;
  logic [31:0] tw_reg;
  logic [31:0] ms_reg;
  logic us_tick;

  assign us_tick = (pre_reg == 8'(SYS_PER_US - 1));
  // Microsecond, twenty-microsecond and millisecond counters, cleared on host command
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_reg <= 8'h00;
      us_reg <= 64'h0;
      tw_pre_reg <= 5'h00;
      tw_reg <= 32'h0;
      ms_pre_reg <= 10'h000;
      ms_reg <= 32'h0;
    end else if (i_clear) begin
      pre_reg <= 8'h00;
      us_reg <= 64'h0;
      tw_pre_reg <= 5'h00;
      tw_reg <= 32'h0;
      ms_pre_reg <= 10'h000;
      ms_reg <= 32'h0;
    end else begin
      pre_reg <= us_tick ? 8'h00 : pre_reg + 8'h01;
      if (us_tick) begin
        us_reg <= us_reg + 64'h1;
        if (tw_pre_reg == 5'(US_PER_TWENTY - 1)) begin
          tw_pre_reg <= 5'h00;
          tw_reg <= tw_reg + 32'h1;
        end else begin
          tw_pre_reg <= tw_pre_reg + 5'h01;
        end
        if (ms_pre_reg == 10'(US_PER_MILLI - 1)) begin
          ms_pre_reg <= 10'h000;
          ms_reg <= ms_reg + 32'h1;
        end else begin
          ms_pre_reg <= ms_pre_reg + 10'h001;
        end
      end
    end
  end

  // Source and resolution select
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_stamp <= 64'h0;
    end else begin
      case (i_mode)
        STAMP_EXTERNAL_TIME: o_stamp <= i_ext_time;
        STAMP_INTERNAL_MICRO: o_stamp <= us_reg;
        STAMP_INTERNAL_TWENTY_MICRO: o_stamp <= {32'h0, tw_reg};
        STAMP_INTERNAL_MILLI: o_stamp <= {32'h0, ms_reg};
        default: o_stamp <= us_reg;
      endcase
    end
  end
endmodule : acc_timestamp

// File: src/acc_channel_config.sv
// APB-configured ARINC 429 channel pair: transmitter framing and receive routing
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ns
module acc_channel_config
  import acc_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Transmit word source
  input wire logic I_TX_VALID,
  input wire logic [31:0] I_TX_WORD,
  output logic O_TX_READY,
  // Line outputs (high and low legs), null when both low
  output logic O_TX_HI,
  output logic O_TX_LO,
  output logic O_TX_FAST_EDGE,
  // External receive line and word framing
  input wire logic I_RX_VALID,
  input wire logic [31:0] I_RX_WORD,
  // Received word to buffers
  output logic O_RX_VALID,
  output logic [31:0] O_RX_WORD,
  output logic O_RX_PARITY_ERR,
  output logic O_RX_TO_SHARED,
  output logic [9:0] O_RX_KEY,
  output logic [63:0] O_RX_STAMP,
  // External time source
  input wire logic [63:0] I_EXT_TIME
);
  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [15:0] rx_rate_select_reg;
  logic [15:0] tx_rate_select_reg;
  logic [31:0] rx_ctrl_reg;
  logic [31:0] tx_ctrl_reg;
  logic [31:0] global_reg;
  logic perr_reg;
  logic timer_clr;
  logic [63:0] stamp;

  logic rx_parity_check_enable;
  logic rx_loopback_select;
  logic rx_queue_enable;
  logic rx_shared_buffer_enable;
  logic [1:0] tx_parity_select;
  logic tx_queue_enable;
  logic tx_output_off;
  logic tx_short_gap_inject;
  logic tx_edge_speed_select;
  logic [3:0] tx_word_size_error;
  logic latest_word_store_key;
  logic [2:0] timestamp_source_select;

  assign rx_parity_check_enable = rx_ctrl_reg[RXC_PARITY_EN];
  assign rx_loopback_select = rx_ctrl_reg[RXC_LOOPBACK];
  assign rx_queue_enable = rx_ctrl_reg[RXC_QUEUE_EN];
  assign rx_shared_buffer_enable = rx_ctrl_reg[RXC_SHARED];
  assign tx_parity_select = tx_ctrl_reg[TXC_PARITY_LSB +: 2];
  assign tx_queue_enable = tx_ctrl_reg[TXC_QUEUE_EN];
  assign tx_output_off = tx_ctrl_reg[TXC_OUTPUT_OFF];
  assign tx_short_gap_inject = tx_ctrl_reg[TXC_GAP_SHORT];
  assign tx_edge_speed_select = tx_ctrl_reg[TXC_EDGE_FAST];
  assign tx_word_size_error = tx_ctrl_reg[TXC_SIZE_LSB +: 4];
  assign latest_word_store_key = global_reg[GLB_KEY];
  assign timestamp_source_select = global_reg[GLB_STAMP_LSB +: 3];

  logic apb_wr;
  logic apb_rd;
  assign apb_wr = I_PSEL && I_PENABLE && I_PWRITE;
  assign apb_rd = I_PSEL && !I_PENABLE && !I_PWRITE;

  function automatic logic addr_known(input logic [7:0] a);
    return (a == ADDR_RX_RATE) || (a == ADDR_TX_RATE) || (a == ADDR_RX_CTRL) ||
           (a == ADDR_TX_CTRL) || (a == ADDR_GLOBAL) || (a == ADDR_TIMER_LO) ||
           (a == ADDR_TIMER_HI) || (a == ADDR_STATUS);
  endfunction : addr_known

  // Register writes
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_rate_select_reg <= RATE_FAST;
      tx_rate_select_reg <= RATE_FAST;
      rx_ctrl_reg <= RST_RX_CTRL;
      tx_ctrl_reg <= RST_TX_CTRL;
      global_reg <= RST_GLOBAL;
    end else if (apb_wr) begin
      case (I_PADDR)
        ADDR_RX_RATE: rx_rate_select_reg <= I_PWDATA[15:0];
        ADDR_TX_RATE: tx_rate_select_reg <= I_PWDATA[15:0];
        ADDR_RX_CTRL: rx_ctrl_reg <= {28'h0, I_PWDATA[3:0]};
        ADDR_TX_CTRL: tx_ctrl_reg <= {20'h0, I_PWDATA[11:8], 2'h0, I_PWDATA[5:0]};
        ADDR_GLOBAL: global_reg <= {25'h0, I_PWDATA[6:4], 3'h0, I_PWDATA[0]};
        default: ;
      endcase
    end
  end

  // Timer clear is a write-one pulse, not stored
  assign timer_clr = apb_wr && (I_PADDR == ADDR_GLOBAL) && I_PWDATA[GLB_TIMER_CLR];

  // ----------------------------------------------------------------
  // APB answer: ready one cycle after setup, data registered
  // ----------------------------------------------------------------
  logic [63:0] timer_now;
  logic tx_busy;
  logic tx_slow_edge;
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PRDATA <= 32'h0;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= I_PSEL && !I_PENABLE;
      O_PSLVERR <= I_PSEL && !I_PENABLE && !addr_known(I_PADDR);
      if (apb_rd) begin
        case (I_PADDR)
          ADDR_RX_RATE: O_PRDATA <= {16'h0, rx_rate_select_reg};
          ADDR_TX_RATE: O_PRDATA <= {16'h0, tx_rate_select_reg};
          ADDR_RX_CTRL: O_PRDATA <= rx_ctrl_reg;
          ADDR_TX_CTRL: O_PRDATA <= tx_ctrl_reg;
          ADDR_GLOBAL: O_PRDATA <= global_reg;
          ADDR_TIMER_LO: O_PRDATA <= timer_now[31:0];
          ADDR_TIMER_HI: O_PRDATA <= timer_now[63:32];
          ADDR_STATUS: O_PRDATA <= {29'h0, tx_slow_edge, perr_reg, tx_busy};
          default: O_PRDATA <= 32'h0;
        endcase
      end else if (I_PSEL && !I_PENABLE) begin
        // Writes answer with zero data, refused ones included
        O_PRDATA <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Time stamp
  // ----------------------------------------------------------------
  acc_timestamp u_stamp (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_clear(timer_clr),
    .i_mode(timestamp_source_select),
    .i_ext_time(I_EXT_TIME),
    .o_stamp(stamp)
  );
  assign timer_now = stamp;

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_GAP} acc_tx_state_t;
  acc_tx_state_t tx_state_reg;
  logic [32:0] tx_shift_reg;
  logic [5:0] tx_count_reg;
  logic [5:0] tx_len;
  logic [5:0] tx_gap;
  logic tx_bit_tick;
  logic tx_half_reg;
  logic [31:0] tx_framed;

  acc_bit_timer u_tx_timer (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_restart(tx_state_reg == TX_IDLE),
    .i_rate(tx_rate_select_reg),
    .o_bit_tick(tx_bit_tick)
  );

  // Word length from size-error code
  always_comb begin
    case (tx_word_size_error)
      SIZE_MISSING_CODE: tx_len = 6'(STD_BITS - 1);
      SIZE_EXTRA_CODE: tx_len = 6'(STD_BITS + 1);
      default: tx_len = 6'(STD_BITS);
    endcase
    tx_gap = tx_short_gap_inject ? 6'(SHORT_GAP) : 6'(STD_GAP);
  end

  // Parity placed in bit 32, or host bit left as is
  always_comb begin
    tx_framed = I_TX_WORD;
    case (tx_parity_select)
      PARITY_ODD_CODE: tx_framed[31] = ~^I_TX_WORD[30:0];
      PARITY_EVEN_CODE: tx_framed[31] = ^I_TX_WORD[30:0];
      default: tx_framed[31] = I_TX_WORD[31];
    endcase
  end

  // Each bit is two half-bit ticks: level then return to zero
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 33'h0;
      tx_count_reg <= 6'h00;
      tx_half_reg <= 1'b0;
      O_TX_READY <= 1'b0;
      O_TX_HI <= 1'b0;
      O_TX_LO <= 1'b0;
    end else begin
      O_TX_READY <= 1'b0;
      case (tx_state_reg)
        TX_IDLE: begin
          O_TX_HI <= 1'b0;
          O_TX_LO <= 1'b0;
          if (I_TX_VALID && tx_queue_enable && !tx_output_off && !O_TX_READY) begin
            tx_shift_reg <= {1'b0, tx_framed};
            tx_count_reg <= tx_len;
            tx_half_reg <= 1'b0;
            O_TX_READY <= 1'b1;
            tx_state_reg <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_output_off) begin
            O_TX_HI <= 1'b0;
            O_TX_LO <= 1'b0;
            tx_state_reg <= TX_IDLE;
          end else if (tx_bit_tick) begin
            tx_half_reg <= ~tx_half_reg;
            if (!tx_half_reg) begin
              O_TX_HI <= tx_shift_reg[0];
              O_TX_LO <= ~tx_shift_reg[0];
            end else begin
              O_TX_HI <= 1'b0;
              O_TX_LO <= 1'b0;
              tx_shift_reg <= {1'b0, tx_shift_reg[32:1]};
              if (tx_count_reg == 6'h01) begin
                tx_count_reg <= tx_gap;
                tx_state_reg <= TX_GAP;
              end else begin
                tx_count_reg <= tx_count_reg - 6'h01;
              end
            end
          end
        end
        TX_GAP: begin
          O_TX_HI <= 1'b0;
          O_TX_LO <= 1'b0;
          if (tx_bit_tick) begin
            tx_half_reg <= ~tx_half_reg;
            if (tx_half_reg) begin
              if (tx_count_reg == 6'h01) begin
                tx_state_reg <= TX_IDLE;
              end else begin
                tx_count_reg <= tx_count_reg - 6'h01;
              end
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end
  assign tx_busy = (tx_state_reg != TX_IDLE);

  // Slew: standard rates follow the select bit; others follow the baud
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_TX_FAST_EDGE <= 1'b0;
    end else if (tx_rate_select_reg == RATE_FAST || tx_rate_select_reg == RATE_SLOW) begin
      O_TX_FAST_EDGE <= tx_edge_speed_select;
    end else begin
      O_TX_FAST_EDGE <= (acc_rate_div(tx_rate_select_reg) <= SLEW_DIV_LIMIT);
    end
  end
  assign tx_slow_edge = ~O_TX_FAST_EDGE;

  // ----------------------------------------------------------------
  // Receiver routing
  // ----------------------------------------------------------------
  logic rx_in_valid;
  logic [31:0] rx_in_word;
  // Loopback takes the framed transmit word in place of the bus
  always_comb begin
    if (rx_loopback_select == LOOPBACK_ON_CODE) begin
      rx_in_valid = O_TX_READY;
      rx_in_word = tx_shift_reg[31:0];
    end else begin
      rx_in_valid = I_RX_VALID;
      rx_in_word = I_RX_WORD;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RX_VALID <= 1'b0;
      O_RX_WORD <= 32'h0;
      O_RX_PARITY_ERR <= 1'b0;
      O_RX_TO_SHARED <= 1'b0;
      O_RX_KEY <= 10'h000;
      O_RX_STAMP <= 64'h0;
      perr_reg <= 1'b0;
    end else begin
      O_RX_VALID <= rx_in_valid && rx_queue_enable;
      if (rx_in_valid) begin
        O_RX_WORD <= rx_in_word;
        O_RX_PARITY_ERR <= rx_parity_check_enable && !(^rx_in_word);
        O_RX_TO_SHARED <= rx_shared_buffer_enable;
        O_RX_KEY <= (latest_word_store_key == KEY_BY_LABEL_AND_SDI) ?
                    rx_in_word[LABEL_W + SDI_W - 1:0] :
                    {2'h0, rx_in_word[LABEL_W - 1:0]};
        O_RX_STAMP <= stamp;
        perr_reg <= rx_parity_check_enable && !(^rx_in_word);
      end
    end
  end
endmodule : acc_channel_config

// File: tb/acc_channel_config_properties.sv
// Port-level assertions for the channel configuration block
`timescale 1ns/1ns
module acc_cc_props (
  input wire logic I_SYS_CLK, I_RST, I_PSEL, I_PENABLE, I_TX_VALID, I_RX_VALID,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY, O_PSLVERR, O_TX_READY, O_TX_HI, O_TX_LO, O_RX_VALID,
  input wire logic [31:0] O_RX_WORD,
  input wire logic O_RX_PARITY_ERR,
  input wire logic [9:0] O_RX_KEY
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  // Bus steps and line activity
  sequence s_setup; I_PSEL && !I_PENABLE; endsequence
  sequence s_answer; I_PSEL && I_PENABLE && O_PREADY; endsequence
  sequence s_leg_up; $rose(O_TX_HI || O_TX_LO); endsequence
  property p_apb_answer; s_setup |=> s_answer; endproperty
  property p_ready_in_access; O_PREADY |-> I_PSEL && I_PENABLE; endproperty
  property p_err_zero; O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h00000000; endproperty
  property p_tx_take; O_TX_READY |-> $past(I_TX_VALID) ##1 !O_TX_READY; endproperty
  property p_null_legs; !(O_TX_HI && O_TX_LO); endproperty
  property p_half_bit; s_leg_up |=> (O_TX_HI || O_TX_LO) [*3]; endproperty
  property p_key_label; O_RX_VALID |-> O_RX_KEY[7:0] == O_RX_WORD[7:0]; endproperty
  property p_perr_even; O_RX_VALID && O_RX_PARITY_ERR |-> !(^O_RX_WORD); endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("pready late");
  a_ready_in_access: assert property (p_ready_in_access) else $error("stray pready");
  a_err_zero: assert property (p_err_zero) else $error("bad error answer");
  a_tx_take: assert property (p_tx_take) else $error("bad tx ready");
  a_null_legs: assert property (p_null_legs) else $error("both legs high");
  a_half_bit: assert property (p_half_bit) else $error("short bit half");
  a_key_label: assert property (p_key_label) else $error("key label");
  a_perr_even: assert property (p_perr_even) else $error("parity flag");
endmodule : acc_cc_props

// File: tb/acc_line_rx.sv
// Far-side bus receiver model that rebuilds transmitted words
`timescale 1ns/1ns
module acc_line_rx (
  input wire logic i_clk,
  input wire logic i_clr,
  input wire logic i_hi,
  input wire logic i_lo,
  output int o_bits,
  output logic [32:0] o_word
);
  logic hi_q = 1'b0;
  logic lo_q = 1'b0;
  // One bit per rising leg, LSB first; null halves carry nothing
  always @(posedge i_clk) begin
    hi_q <= i_hi;
    lo_q <= i_lo;
    if (i_clr) begin
      o_bits <= 0;
    end else if ((i_hi && !hi_q) || (i_lo && !lo_q)) begin
      o_word[o_bits] <= i_hi;
      o_bits <= o_bits + 1;
    end
  end
endmodule : acc_line_rx

// File: tb/acc_channel_config_tb_top.sv
// Self-checking bench for the channel configuration block
`timescale 1ns/1ns
module acc_channel_config_tb_top;
  import acc_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, txv = 0, rxv = 0, clr = 0, re;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 0, prd, txw = 0, rxw = 0, rd, lf = 32'h38F2B082, ow;
  logic [63:0] ext = 0, stp;
  logic rdy, err, txr, hi, lo, fe, rv, pe, sh;
  logic [9:0] key;
  logic [32:0] pw;
  int bits, error_cnt = 0, check_count = 0, cyc = 0;
  int rt [4] = '{0, 1, 1064, 1100};
  always #2 clk = ~clk;
  acc_channel_config dut (.I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy),
    .O_PSLVERR(err), .I_TX_VALID(txv), .I_TX_WORD(txw), .O_TX_READY(txr), .O_TX_HI(hi),
    .O_TX_LO(lo), .O_TX_FAST_EDGE(fe), .I_RX_VALID(rxv), .I_RX_WORD(rxw), .O_RX_VALID(rv),
    .O_RX_WORD(ow), .O_RX_PARITY_ERR(pe), .O_RX_TO_SHARED(sh), .O_RX_KEY(key),
    .O_RX_STAMP(stp), .I_EXT_TIME(ext));
  acc_line_rx far (.i_clk(clk), .i_clr(clr), .i_hi(hi), .i_lo(lo), .o_bits(bits), .o_word(pw));
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : rnd
  // Expected bit 32 for each parity code
  function automatic logic par(input int c, input logic [31:0] w);
    return c == 0 ? ~^w[30:0] : c == 1 ? ^w[30:0] : w[31];
  endfunction : par
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    {re, rd} = {err, prd};
    {psel, pen} <= 2'b00;
  endtask : apb
  // Hand one word to the transmitter and wait for the line to go idle
  task automatic send(input logic [31:0] w);
    @(posedge clk);
    {clr, txv, txw} <= {2'b11, w};
    do @(posedge clk); while (txr !== 1'b1);
    {clr, txv, txw} <= {2'b00, ~w};
    do apb(1'b0, ADDR_STATUS, 0); while (rd[STS_TX_BUSY] !== 1'b0);
  endtask : send
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc > 60000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    logic [31:0] w, x;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_RX_CTRL, 0);
    chk({re, rd}, {1'b0, RST_RX_CTRL});
    apb(1'b0, ADDR_TX_CTRL, 0);
    chk({re, rd}, {1'b0, RST_TX_CTRL});
    apb(1'b0, ADDR_GLOBAL, 0);
    chk({re, rd}, {1'b0, RST_GLOBAL});
    apb(1'b1, 8'h20, 32'hFFFFFFFF);
    apb(1'b0, 8'h20, 0);
    chk({re, rd}, {1'b1, 32'h00000000});
    w = rnd() & 32'h0000FFFF;
    apb(1'b1, ADDR_RX_RATE, w);
    apb(1'b0, ADDR_RX_RATE, 0);
    chk(rd, w);
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_TX_RATE, rt[i]);
      apb(1'b1, ADDR_TX_CTRL, 32'h00000804 | (32'(i == 0 || i == 3) << TXC_EDGE_FAST));
      repeat (2) @(posedge clk);
      chk(fe, rt[i] < 2 ? (i == 0 || i == 3) : 16000000 / (rt[i] + 2) >= 15000);
    end
    $display("edge speed test done");
    apb(1'b1, ADDR_TX_RATE, 32'h00000006);
    apb(1'b1, ADDR_RX_CTRL, 32'h00000005);
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, ADDR_TX_CTRL, {20'h00000, c < 3 ? 4'h8 : 4'(c - 3), 6'h01, 2'(c < 3 ? c : 0)});
      w = rnd();
      send(w);
      chk(bits, c == 3 ? 31 : c == 4 ? 33 : 32);
      chk(pw[30:0], w[30:0]);
      x = {par(c < 3 ? c : 0, w), w[30:0]};
      chk({pe, ow}, {~^x, x});
      if (c < 3) chk(pw[31], par(c, w));
    end
    $display("transmit framing test done");
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_TX_CTRL, i ? 32'h00000800 : 32'h0000080C);
      {clr, txv} <= 2'b11;
      @(posedge clk);
      clr <= 1'b0;
      repeat (300) @(posedge clk);
      chk({bits, hi, lo}, 0);
      txv <= 1'b0;
    end
    $display("transmit off test done");
    ext = {rnd(), rnd()};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_RX_CTRL, i == 3 ? 32'h0000000A : i[0] ? 32'h00000007 : 32'h0000000E);
      apb(1'b1, ADDR_GLOBAL, {31'h00000000, i[1]});
      w = rnd();
      @(posedge clk);
      {rxv, rxw} <= {1'b1, w};
      @(posedge clk);
      {rxv, rxw} <= {1'b0, ~w};
      @(posedge clk);
      chk(rv, i != 3);
      if (i != 3) chk({sh, pe, key, ow, stp}, {~i[0], i[0] & ~^w,
        i[1] ? w[9:0] : {2'b00, w[7:0]}, w, ext});
    end
    $display("receive test done");
    apb(1'b1, ADDR_GLOBAL, 32'h00000110);
    apb(1'b0, ADDR_TIMER_LO, 0);
    chk(rd, 0);
    repeat (600) @(posedge clk);
    apb(1'b0, ADDR_TIMER_LO, 0);
    chk(rd, 2);
    $display("timer test done");
    report_and_stop();
  end
endmodule : acc_channel_config_tb_top
bind acc_channel_config acc_cc_props props (.*);
